// *** dscc_pkg.sv ***
// shared constants and types for the serial converter command control
package dscc_pkg;
    // serial word layout
    localparam int unsigned WORD_BITS = 16;
    localparam int unsigned CODE_BITS = 13;
    localparam int unsigned CTRL_BITS = 3;
    localparam int unsigned CTRL_LSB = 13;
    localparam int unsigned COUNT_W = 5;
    localparam logic [4:0] BITS_FULL = 5'h10;
    localparam logic [4:0] BITS_OVER = 5'h11;
    localparam logic [4:0] BITS_FIRST = 5'h01;

    // control codes; the low pair picks the action, the top bit only matters for the 11 pair
    localparam logic [1:0] LOW_LOAD_UPDATE = 2'h0;
    localparam logic [1:0] LOW_LOAD_ONLY = 2'h1;
    localparam logic [1:0] LOW_UPDATE = 2'h2;
    localparam logic [1:0] LOW_SPECIAL = 2'h3;
    localparam logic [2:0] CTRL_SHUTDOWN = 3'h7;
    localparam logic [2:0] CTRL_NOP = 3'h3;

    // values after reset
    localparam logic [12:0] CODE_RESET = 13'h0000;
    localparam logic SEL_IDLE = 1'b1;

    // output settling after power-up or wake
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned SETTLE_TIME_US = 20;
    localparam int unsigned SETTLE_CYCLES = (SETTLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SETTLE_W = 9;
    localparam logic [8:0] SETTLE_LAST = 9'(SETTLE_CYCLES - 1);
    localparam logic [8:0] SETTLE_ZERO = 9'h000;
    localparam logic [8:0] SETTLE_STEP = 9'h001;

    // power state, gray along settle -> active -> shutdown
    typedef enum logic [1:0] {
        ST_SETTLE = 2'h0,
        ST_ACTIVE = 2'h1,
        ST_SHUTDOWN = 2'h3
    } dscc_state_e;
endpackage : dscc_pkg

// *** dscc_link_if.sv ***
// frame contents handed from the serial clock domain to the core
`timescale 1ns/1ps
interface dscc_link_if;
    logic [dscc_pkg::WORD_BITS-1:0] word;
    logic [dscc_pkg::COUNT_W-1:0] bit_count;
    logic fresh;

    modport rx (
        output word,
        output bit_count,
        output fresh
    );
    modport core (
        input word,
        input bit_count,
        input fresh
    );
endinterface : dscc_link_if

// *** dscc_shift_rx.sv ***
// serial shift register running on the host's serial clock
`timescale 1ns/1ps
module dscc_shift_rx (
    // link pins
    input wire logic ser_clk,
    input wire logic sel_n,
    input wire logic ser_data,
    // frame contents toward the core
    dscc_link_if.rx link
);
    logic [dscc_pkg::WORD_BITS-1:0] shift_q;
    logic [dscc_pkg::COUNT_W-1:0] count_q;
    logic fresh_q;
    wire logic [dscc_pkg::COUNT_W-1:0] count_inc;
    wire logic [dscc_pkg::COUNT_W-1:0] count_d;

    // count saturates one past a full word so an overlong frame stays visible
    assign count_inc = (count_q == dscc_pkg::BITS_OVER) ? count_q : count_q + dscc_pkg::BITS_FIRST;
    assign count_d = fresh_q ? dscc_pkg::BITS_FIRST : count_inc;

    // set while deselected; the serial clock may stand still, so select itself restarts the frame
    always_ff @(posedge ser_clk or posedge sel_n) begin
        if (sel_n) begin
            fresh_q <= 1'b1; // R3
        end else begin
            fresh_q <= 1'b0;
        end
    end

    // msb arrives first, so shifting left leaves the word in natural order
    always_ff @(posedge ser_clk) begin
        if (!sel_n) begin
            shift_q <= {shift_q[dscc_pkg::WORD_BITS-2:0], ser_data}; // R4 R1
            count_q <= count_d;
        end
    end

    // contents stay frozen while select is high, which is what lets the core sample them
    assign link.word = shift_q;
    assign link.bit_count = count_q;
    assign link.fresh = fresh_q;
endmodule : dscc_shift_rx

// *** dscc_serial_dac_ctrl.sv ***
// command decode, double-buffered code registers and shutdown control
`timescale 1ns/1ps

// Functional notes
// R1 - sixteen bit word, three control, msb first
// R2 - host keeps select low for whole word
// R3 - deselected device ignores clock and data
// R4 - data shifts in on serial clock rise
// R5 - command executes at select rising edge
// R6 - host keeps serial clock at most 10MHz; the host model shifts with a 32ns period, about 31.25MHz
// R7 - x00 loads input, updates output, wakes
// R8 - x01 loads input register only
// R9 - x10 copies input to output, wakes
// R10 - 111 enters shutdown, data ignored
// R11 - shutdown disables amplifier and reference input
// R12 - shifting and decode stay alive in shutdown
// R13 - shutdown keeps input register contents
// R14 - host waits 20us before trusting output
// R15 - reset clears input and output registers
// R16 - shared lines need one select each
// R17 - code is unsigned straight binary
// R18 - 011 changes nothing
module dscc_serial_dac_ctrl (
    // core clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // serial link from the host
    input wire logic ser_clk,
    input wire logic sel_n,
    input wire logic ser_data,
    // code toward the converter
    output logic [dscc_pkg::CODE_BITS-1:0] dac_code,
    output logic [dscc_pkg::CODE_BITS-1:0] input_code,
    // power control toward the analog part
    output logic amp_out_en,
    output logic ref_in_en,
    // status
    output logic shutdown,
    output logic output_settled,
    output logic cmd_done,
    output logic frame_error
);
    dscc_link_if link ();

    dscc_shift_rx u_rx (
        .ser_clk (ser_clk),
        .sel_n (sel_n),
        .ser_data (ser_data),
        .link (link.rx)
    );

    // select crossing; meta stage feeds only the sync stage
    logic sel_meta_q;
    logic sel_sync_q;
    logic sel_prev_q;
    logic frame_open_q;

    // frame captured in the core domain
    logic [dscc_pkg::WORD_BITS-1:0] cap_word_q;
    logic [dscc_pkg::COUNT_W-1:0] cap_count_q;
    logic exec_q;

    // architectural state
    logic [dscc_pkg::CODE_BITS-1:0] input_q;
    logic [dscc_pkg::CODE_BITS-1:0] input_d;
    logic [dscc_pkg::CODE_BITS-1:0] conv_q;
    logic [dscc_pkg::CODE_BITS-1:0] conv_d;
    dscc_pkg::dscc_state_e state_q;
    dscc_pkg::dscc_state_e state_d;
    logic [dscc_pkg::SETTLE_W-1:0] settle_q;
    logic [dscc_pkg::SETTLE_W-1:0] settle_d;

    // registered outputs
    logic amp_en_q;
    logic ref_en_q;
    logic shutdown_q;
    logic settled_q;
    logic done_q;
    logic err_q;

    wire logic sel_rise;
    wire logic sel_fall;
    wire logic capture;
    wire logic [dscc_pkg::CTRL_BITS-1:0] ctrl;
    wire logic [dscc_pkg::CODE_BITS-1:0] code;
    wire logic frame_ok;
    wire logic run;
    wire logic bad;
    wire logic do_load;
    wire logic do_load_update;
    wire logic do_recall;
    wire logic do_shutdown;
    wire logic do_wake;
    wire logic settle_end;

    // edges are taken from the synchronised level, never from the meta stage
    assign sel_rise = sel_sync_q & ~sel_prev_q;
    assign sel_fall = ~sel_sync_q & sel_prev_q;
    // a select pulse too short to be seen low is treated as no frame at all
    assign capture = sel_rise & frame_open_q; // R5

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            sel_meta_q <= dscc_pkg::SEL_IDLE;
            sel_sync_q <= dscc_pkg::SEL_IDLE;
            sel_prev_q <= dscc_pkg::SEL_IDLE;
            frame_open_q <= 1'b0;
        end else begin
            sel_meta_q <= sel_n;
            sel_sync_q <= sel_meta_q;
            sel_prev_q <= sel_sync_q;
            frame_open_q <= sel_fall | (frame_open_q & ~sel_rise);
        end
    end

    // the link side freezes once select is high; sampling two to three core cycles later
    // is safe because the host must keep select high and then wait its setup before the
    // next shift, which together exceed the crossing delay
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            cap_word_q <= '0;
            cap_count_q <= '0;
            exec_q <= 1'b0;
        end else begin
            exec_q <= capture; // R5
            if (capture) begin
                cap_word_q <= link.word;
                cap_count_q <= link.bit_count;
            end
        end
    end

    // decode
    assign ctrl = cap_word_q[dscc_pkg::WORD_BITS-1:dscc_pkg::CTRL_LSB]; // R1
    assign code = cap_word_q[dscc_pkg::CODE_BITS-1:0]; // R1
    // short or overlong frames are dropped whole rather than guessed at
    // the fresh flag is set again by the very select rise that ends the frame, so only the count is judged
    assign frame_ok = cap_count_q == dscc_pkg::BITS_FULL; // R2
    assign run = exec_q & frame_ok; // R12
    assign bad = exec_q & ~frame_ok;
    assign do_load_update = run & (ctrl[1:0] == dscc_pkg::LOW_LOAD_UPDATE); // R7
    assign do_load = run & ((ctrl[1:0] == dscc_pkg::LOW_LOAD_UPDATE) | (ctrl[1:0] == dscc_pkg::LOW_LOAD_ONLY)); // R8
    assign do_recall = run & (ctrl[1:0] == dscc_pkg::LOW_UPDATE); // R9
    assign do_shutdown = run & (ctrl == dscc_pkg::CTRL_SHUTDOWN); // R10
    // the 011 word matches none of the terms above and so leaves every register alone
    assign do_wake = do_load_update | do_recall;
    assign settle_end = settle_q == dscc_pkg::SETTLE_LAST;

    // shutdown does not touch the input register, so a later recall restores the output
    assign input_d = do_load ? code : input_q; // R8 R13
    assign conv_d = do_load_update ? code : (do_recall ? input_q : conv_q); // R7 R9

    always_comb begin
        state_d = state_q;
        case (state_q)
            dscc_pkg::ST_SETTLE: begin
                if (do_shutdown) begin
                    state_d = dscc_pkg::ST_SHUTDOWN; // R10
                end else if (settle_end) begin
                    state_d = dscc_pkg::ST_ACTIVE; // R14
                end
            end
            dscc_pkg::ST_ACTIVE: begin
                if (do_shutdown) begin
                    state_d = dscc_pkg::ST_SHUTDOWN; // R10
                end
            end
            dscc_pkg::ST_SHUTDOWN: begin
                if (do_wake) begin
                    state_d = dscc_pkg::ST_SETTLE; // R7 R9
                end
            end
            default: begin
                state_d = dscc_pkg::ST_SETTLE;
            end
        endcase
    end

    // restarts on every entry into settling, including a wake straight from shutdown
    assign settle_d = ((state_q == dscc_pkg::ST_SETTLE) && (state_d == dscc_pkg::ST_SETTLE))
                      ? settle_q + dscc_pkg::SETTLE_STEP : dscc_pkg::SETTLE_ZERO; // R14

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            input_q <= dscc_pkg::CODE_RESET; // R15
            conv_q <= dscc_pkg::CODE_RESET; // R15
            state_q <= dscc_pkg::ST_SETTLE;
            settle_q <= dscc_pkg::SETTLE_ZERO;
        end else begin
            input_q <= input_d;
            conv_q <= conv_d;
            state_q <= state_d;
            settle_q <= settle_d;
        end
    end

    // power and settle outputs follow the next state, done and error follow the decode, so they move in the same edge as the registers
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            amp_en_q <= 1'b1;
            ref_en_q <= 1'b1;
            shutdown_q <= 1'b0;
            settled_q <= 1'b0;
            done_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            amp_en_q <= state_d != dscc_pkg::ST_SHUTDOWN; // R11
            ref_en_q <= state_d != dscc_pkg::ST_SHUTDOWN; // R11
            shutdown_q <= state_d == dscc_pkg::ST_SHUTDOWN;
            settled_q <= state_d == dscc_pkg::ST_ACTIVE;
            done_q <= run;
            err_q <= bad;
        end
    end

    // unsigned straight binary; full scale is the code over 8192 of the reference
    assign dac_code = conv_q; // R17
    assign input_code = input_q;
    assign amp_out_en = amp_en_q;
    assign ref_in_en = ref_en_q;
    assign shutdown = shutdown_q;
    assign output_settled = settled_q;
    assign cmd_done = done_q;
    assign frame_error = err_q;
endmodule : dscc_serial_dac_ctrl

// *** dscc_serial_dac_ctrl_chk.sv ***
// port-level checks for the converter command control
`timescale 1ns/1ps
module dscc_serial_dac_ctrl_chk (
    // core clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // serial link
    input wire logic ser_clk,
    input wire logic sel_n,
    input wire logic ser_data,
    // outputs under watch
    input wire logic [dscc_pkg::CODE_BITS-1:0] dac_code,
    input wire logic [dscc_pkg::CODE_BITS-1:0] input_code,
    input wire logic amp_out_en,
    input wire logic ref_in_en,
    input wire logic shutdown,
    input wire logic output_settled,
    input wire logic cmd_done,
    input wire logic frame_error
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    a_done_pulse: assert property (cmd_done |=> !cmd_done) else $error("command pulse too long");
    a_dac_cause: assert property ($changed(dac_code) |-> cmd_done) else $error("converter code moved alone");
    a_input_cause: assert property ($changed(input_code) |-> cmd_done) else $error("input code moved alone");
    a_shut_enables: assert property (amp_out_en == !shutdown && ref_in_en == !shutdown)
        else $error("enables disagree with shutdown");
    a_err_no_change: assert property (frame_error |-> $stable(dac_code) && $stable(input_code) && $stable(shutdown))
        else $error("bad frame changed state");
    a_shut_keeps: assert property ($rose(shutdown) |-> $stable(input_code) && $stable(dac_code))
        else $error("shutdown altered codes");
    // a result shows at most four core cycles after select rises
    a_sel_idle_quiet: assert property (sel_n [*6] |=> !cmd_done && !frame_error)
        else $error("activity while deselected");
    a_wake_settle: assert property ($fell(shutdown) |-> !output_settled) else $error("settled on wake");
    c_done: cover property (cmd_done);
    c_error: cover property (frame_error);
    c_shut: cover property ($rose(shutdown));
endmodule : dscc_serial_dac_ctrl_chk
bind dscc_serial_dac_ctrl dscc_serial_dac_ctrl_chk chk (.ref_clk(ref_clk), .reset_n(reset_n), .ser_clk(ser_clk),
    .sel_n(sel_n), .ser_data(ser_data), .dac_code(dac_code), .input_code(input_code), .amp_out_en(amp_out_en),
    .ref_in_en(ref_in_en), .shutdown(shutdown), .output_settled(output_settled), .cmd_done(cmd_done),
    .frame_error(frame_error));

// *** dscc_host_model.sv ***
// host serial master driving the three link wires
`timescale 1ns/1ps
module dscc_host_model (
    // link wires
    output logic ser_clk,
    output logic sel_n,
    output logic ser_data
);
    initial begin
        ser_clk = 1'b0;
        sel_n = 1'b0;
        ser_data = 1'b0;
        // power-up select pulse gives the unreset link side a known frame start
        #10 sel_n = 1'b1;
    end
    task automatic start();
        sel_n = 1'b0;
        #40;
    endtask : start
    // link clock runs inside frames, and also while deselected when idle_noise calls this task
    task automatic shift(input logic b);
        ser_data = b;
        #16 ser_clk = 1'b1;
        #16 ser_clk = 1'b0;
    endtask : shift
    // released data line shows the inverse so a stale bit is never mistaken for data
    task automatic stop();
        #16 sel_n = 1'b1;
        ser_data = ~ser_data;
    endtask : stop
    task automatic idle_noise();
        repeat (8) shift(~ser_data);
    endtask : idle_noise
endmodule : dscc_host_model

// *** testbench.sv ***
// self-checking bench for the converter command control
`timescale 1ns/1ps
module testbench;
    logic ref_clk;
    logic reset_n;
    wire ser_clk;
    wire sel_n;
    wire ser_data;
    logic [12:0] dac_code;
    logic [12:0] input_code;
    logic amp_out_en;
    logic ref_in_en;
    logic shutdown;
    logic output_settled;
    logic cmd_done;
    logic frame_error;
    int mismatches;
    int checked;
    dscc_host_model host (.ser_clk(ser_clk), .sel_n(sel_n), .ser_data(ser_data));
    dscc_serial_dac_ctrl dut (.ref_clk(ref_clk), .reset_n(reset_n), .ser_clk(ser_clk), .sel_n(sel_n),
        .ser_data(ser_data), .dac_code(dac_code), .input_code(input_code), .amp_out_en(amp_out_en),
        .ref_in_en(ref_in_en), .shutdown(shutdown), .output_settled(output_settled), .cmd_done(cmd_done),
        .frame_error(frame_error));
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic results();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results
    task automatic cmp(input logic [28:0] got, input logic [28:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    // power field is amp enable, reference enable, shutdown
    task automatic state(input logic [12:0] ei, input logic [12:0] ed, input logic [2:0] ep);
        cmp({input_code, dac_code, amp_out_en, ref_in_en, shutdown}, {ei, ed, ep});
    endtask : state
    // bits past sixteen are zero; split pauses after the first byte
    task automatic xfer(input logic [15:0] w, input int n, input logic split, input logic err);
        int k;
        @(negedge ref_clk);
        host.start();
        for (k = 0; k < n; k++) begin
            host.shift(k < 16 ? w[15 - k] : 1'b0);
            if (split && k == 7) #200;
        end
        host.stop();
        for (k = 0; k < 12 && cmd_done !== 1'b1 && frame_error !== 1'b1; k++) @(negedge ref_clk);
        cmp({27'h0, cmd_done, frame_error}, {27'h0, ~err, err});
        @(negedge ref_clk);
    endtask : xfer
    task automatic t_load_only();
        xfer(16'h3abc, 16, 1'b0, 1'b0);
        state(13'h1abc, 13'h0000, 3'b110);
    endtask : t_load_only
    task automatic t_update();
        xfer(16'hc555, 16, 1'b0, 1'b0);
        state(13'h1abc, 13'h1abc, 3'b110);
    endtask : t_update
    task automatic t_load_update();
        xfer(16'h9fff, 16, 1'b1, 1'b0);
        state(13'h1fff, 13'h1fff, 3'b110);
    endtask : t_load_update
    task automatic t_shutdown();
        xfer(16'hf0f0, 16, 1'b0, 1'b0);
        state(13'h1fff, 13'h1fff, 3'b001);
    endtask : t_shutdown
    task automatic t_asleep();
        xfer(16'h2123, 16, 1'b0, 1'b0);
        state(13'h0123, 13'h1fff, 3'b001);
        xfer(16'h7fff, 16, 1'b0, 1'b0);
        state(13'h0123, 13'h1fff, 3'b001);
        xfer(16'h4000, 16, 1'b0, 1'b0);
        state(13'h0123, 13'h0123, 3'b110);
        repeat (498) @(negedge ref_clk);
        cmp({28'h0, output_settled}, 29'h0);
        @(negedge ref_clk);
        cmp({28'h0, output_settled}, 29'h1);
    endtask : t_asleep
    task automatic t_deselect();
        host.idle_noise();
        repeat (10) @(negedge ref_clk);
        state(13'h0123, 13'h0123, 3'b110);
    endtask : t_deselect
    task automatic t_bad_length();
        xfer(16'h0fff, 15, 1'b0, 1'b1);
        xfer(16'h0fff, 17, 1'b0, 1'b1);
        state(13'h0123, 13'h0123, 3'b110);
    endtask : t_bad_length
    initial begin
        reset_n = 1'b0;
        mismatches = 0;
        checked = 0;
        repeat (12) @(negedge ref_clk);
        reset_n = 1'b1;
        @(negedge ref_clk);
        state(13'h0000, 13'h0000, 3'b110);
        t_load_only();
        t_update();
        t_load_update();
        t_shutdown();
        t_asleep();
        t_deselect();
        t_bad_length();
        results();
    end
    initial begin
        #300000;
        mismatches++;
        results();
    end
endmodule : testbench
